// ### hdl/acr_pkg.sv
// Constants and carrier types for the line-input routing register bank
package acr_pkg;

  localparam int          ACR_ADDR_W       = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  ACR_IDX_LEFT     = 8'h15;
  localparam logic [7:0]  ACR_IDX_RIGHT    = 8'h16;

  // Field positions
  localparam int          ACR_DIFF_BIT     = 7;
  localparam int          ACR_LEVEL_LSB    = 3;
  localparam int          ACR_LEVEL_W      = 4;
  localparam int          ACR_POWER_BIT    = 2;
  localparam int          ACR_RATE_LSB     = 0;
  localparam int          ACR_RATE_W       = 2;

  // Reset values
  localparam logic        ACR_DIFF_RST     = 1'b0;
  localparam logic [3:0]  ACR_LEVEL_RST    = 4'hF;
  localparam logic        ACR_POWER_RST    = 1'b0;
  localparam logic [1:0]  ACR_RATE_RST     = 2'h0;
  localparam logic [2:0]  ACR_LEFT_RSVD    = 3'h0;

  // Level codes
  localparam logic [3:0]  ACR_LEVEL_0DB    = 4'h0;
  localparam logic [3:0]  ACR_LEVEL_MAX    = 4'h8;
  localparam logic [3:0]  ACR_LEVEL_OFF    = 4'hF;

  // Soft-step rates
  localparam logic [1:0]  ACR_RATE_FS1     = 2'h0;
  localparam logic [1:0]  ACR_RATE_FS2     = 2'h1;

  // Bus answers
  localparam logic [1:0]  ACR_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  ACR_RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic                  awvalid;
    logic [ACR_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [ACR_ADDR_W-1:0] araddr;
    logic                  rready;
  } acr_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } acr_axil_rsp_t;

  typedef struct packed {
    logic       left_diff;
    logic [3:0] left_level;
    logic       left_connect;
    logic       right_diff;
    logic [3:0] right_level;
    logic       right_connect;
    logic       right_power;
    logic       right_step_busy;
  } acr_route_t;

endpackage : acr_pkg

// ### hdl/acr_soft_step.sv
// Soft-stepping of the right ADC mix level toward its programmed target
`timescale 1ns/100ps
module acr_soft_step (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  target,
  input  wire logic [1:0]  rate,
  input  wire logic        fs_tick,
  output logic      [3:0]  level,
  output logic             busy
);
  import acr_pkg::*;

  typedef struct packed {
    logic [3:0] level;
    logic       half;
    logic       busy;
  } acr_step_state_t;

  acr_step_state_t st;
  acr_step_state_t next_st;
  logic            step_now;
  logic            stepping;

  always_comb begin
    next_st  = st;
    stepping = (rate == ACR_RATE_FS1) || (rate == ACR_RATE_FS2);
    step_now = fs_tick && ((rate == ACR_RATE_FS1) || st.half);
    if (fs_tick) begin
      next_st.half = ~st.half;
    end
    if (st.level != target) begin
      // Connect, disconnect or disabled stepping apply at once
      if (!stepping || target == ACR_LEVEL_OFF ||
          st.level == ACR_LEVEL_OFF) begin
        next_st.level = target;
      end else if (step_now) begin // [RL10]
        if (st.level < target) begin
          next_st.level = st.level + 4'h1;
        end else begin
          next_st.level = st.level - 4'h1;
        end
      end
    end
    next_st.busy = (next_st.level != target);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '{level: ACR_LEVEL_RST, half: 1'b0, busy: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
  assign busy  = st.busy;

endmodule : acr_soft_step

// ### hdl/acr_route_regs.sv
// Left and right line-one input routing registers behind an AXI4-Lite slave
// Behaviour
// [RL1] Bit 7 of each register picks single-ended (0) or differential (1), reset 0.
// [RL2] Software keeps the mode bit equal in both registers when routed to both.
// [RL3] Left level field bits 6..3 gives 0 dB at 0000 down to -12 dB at 1000, reset 1111.
// [RL4] Any valid left code connects the input to the left mix; 1111 disconnects it.
// [RL5] Software never writes level codes 1001 to 1110.
// [RL6] Left register bits 2..0 read zero and software writes zero there.
// [RL7] Right register has its own level field, same coding, 1111 disconnects.
// [RL8] Right register bit 2 powers the right ADC channel up (1) or down (0), reset 0.
// [RL9] Right bits 1..0 set soft-step rate: 00 each Fs, 01 every two Fs, 1x off.
// [RL10] With stepping on, the right level walks one step per interval to target.
`timescale 1ns/100ps
module acr_route_regs (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire acr_pkg::acr_axil_req_t axil_req,
  output acr_pkg::acr_axil_rsp_t      axil_rsp,
  input  wire logic                   fs_tick,
  output acr_pkg::acr_route_t         route
);
  import acr_pkg::*;

  localparam logic [ACR_ADDR_W-1:0] ADDR_LEFT =
    ACR_ADDR_W'({ACR_IDX_LEFT, 2'b00});
  localparam logic [ACR_ADDR_W-1:0] ADDR_RIGHT =
    ACR_ADDR_W'({ACR_IDX_RIGHT, 2'b00});

  typedef struct packed {
    logic                  aw_held;
    logic [ACR_ADDR_W-1:0] aw_addr;
    logic                  w_held;
    logic [7:0]            w_byte;
    logic                  w_en;
    logic [7:0]            left_reg;
    logic [7:0]            right_reg;
    acr_axil_rsp_t         rsp;
    acr_route_t            out;
  } acr_regs_state_t;

  acr_regs_state_t st;
  acr_regs_state_t next_st;
  logic [3:0]      step_level;
  logic            step_busy;
  logic            aw_take;
  logic            w_take;
  logic            ar_take;

  acr_soft_step u_step (
    .aclk    (aclk),
    .aresetn (aresetn),
    .target  (st.right_reg[ACR_LEVEL_LSB +: ACR_LEVEL_W]),
    .rate    (st.right_reg[ACR_RATE_LSB +: ACR_RATE_W]),
    .fs_tick (fs_tick),
    .level   (step_level),
    .busy    (step_busy)
  );

  always_comb begin
    next_st = st;
    aw_take = axil_req.awvalid && st.rsp.awready;
    w_take  = axil_req.wvalid && st.rsp.wready;
    ar_take = axil_req.arvalid && st.rsp.arready;

    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = axil_req.awaddr;
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.w_byte = axil_req.wdata[7:0];
      next_st.w_en   = axil_req.wstrb[0];
    end

    // Write once both halves are held
    if (st.aw_held && st.w_held && !st.rsp.bvalid) begin
      next_st.aw_held    = 1'b0;
      next_st.w_held     = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp  = ACR_RESP_OKAY;
      if (st.aw_addr == ADDR_LEFT) begin
        if (st.w_en) begin
          next_st.left_reg = {st.w_byte[7:3], ACR_LEFT_RSVD}; // [RL6]
        end
      end else if (st.aw_addr == ADDR_RIGHT) begin
        if (st.w_en) begin
          next_st.right_reg = st.w_byte; // [RL7] [RL8] [RL9]
        end
      end else begin
        next_st.rsp.bresp = ACR_RESP_SLVERR;
      end
    end else if (st.rsp.bvalid && axil_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end

    if (ar_take) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rresp  = ACR_RESP_OKAY;
      if (axil_req.araddr == ADDR_LEFT) begin
        next_st.rsp.rdata = {24'h00_0000, st.left_reg}; // [RL6]
      end else if (axil_req.araddr == ADDR_RIGHT) begin
        next_st.rsp.rdata = {24'h00_0000, st.right_reg};
      end else begin
        next_st.rsp.rdata = 32'h0000_0000;
        next_st.rsp.rresp = ACR_RESP_SLVERR;
      end
    end else if (st.rsp.rvalid && axil_req.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end

    next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
    next_st.rsp.wready  = !next_st.w_held && !next_st.rsp.bvalid;
    next_st.rsp.arready = !next_st.rsp.rvalid;

    // Analog-side controls
    next_st.out.left_diff   = st.left_reg[ACR_DIFF_BIT]; // [RL1]
    next_st.out.left_level  =
      st.left_reg[ACR_LEVEL_LSB +: ACR_LEVEL_W]; // [RL3]
    next_st.out.left_connect =
      st.left_reg[ACR_LEVEL_LSB +: ACR_LEVEL_W] != ACR_LEVEL_OFF; // [RL4]
    next_st.out.right_diff  = st.right_reg[ACR_DIFF_BIT]; // [RL1]
    next_st.out.right_level = step_level; // [RL10]
    next_st.out.right_connect = step_level != ACR_LEVEL_OFF; // [RL7]
    next_st.out.right_power = st.right_reg[ACR_POWER_BIT]; // [RL8]
    next_st.out.right_step_busy = step_busy; // [RL9]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st.aw_held   <= 1'b0;
      st.aw_addr   <= '0;
      st.w_held    <= 1'b0;
      st.w_byte    <= 8'h00;
      st.w_en      <= 1'b0;
      st.left_reg  <= {ACR_DIFF_RST, ACR_LEVEL_RST, ACR_LEFT_RSVD};
      st.right_reg <= {ACR_DIFF_RST, ACR_LEVEL_RST, ACR_POWER_RST,
                       ACR_RATE_RST};
      st.rsp       <= '{awready: 1'b0, wready: 1'b0, bvalid: 1'b0,
                        bresp: ACR_RESP_OKAY, arready: 1'b0,
                        rvalid: 1'b0, rdata: 32'h0000_0000,
                        rresp: ACR_RESP_OKAY};
      st.out       <= '{left_diff: ACR_DIFF_RST,
                        left_level: ACR_LEVEL_RST, left_connect: 1'b0,
                        right_diff: ACR_DIFF_RST,
                        right_level: ACR_LEVEL_RST, right_connect: 1'b0,
                        right_power: ACR_POWER_RST,
                        right_step_busy: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign axil_rsp = st.rsp;
  assign route    = st.out;

endmodule : acr_route_regs

// ### test/acr_route_regs_sva.sv
// Port checker for the line-input routing register bank
`timescale 1ns/100ps
module acr_route_regs_chk (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire acr_pkg::acr_axil_req_t axil_req,
  input wire acr_pkg::acr_axil_rsp_t axil_rsp,
  input wire logic                   fs_tick,
  input wire acr_pkg::acr_route_t    route
);
  import acr_pkg::*;
  logic [7:0] ra;
  always_ff @(posedge aclk) begin
    if (axil_req.arvalid && axil_rsp.arready)
      ra <= axil_req.araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_step;
    $changed(route.right_level) && $past(route.right_step_busy) &&
    route.right_level != 4'hF && $past(route.right_level) != 4'hF;
  endsequence
  chk_reset_route: assert property ($rose(aresetn) |->
    route.left_level == 4'hF && route.right_level == 4'hF &&
    !route.right_power && !route.left_diff) else $error("route reset");
  chk_left_conn: assert property (
    route.left_connect == (route.left_level != 4'hF)) else $error("lconn");
  chk_right_conn: assert property (
    route.right_connect == (route.right_level != 4'hF)) else $error("rconn");
  chk_step_tick: assert property (s_step |-> $past(fs_tick, 2))
    else $error("step off tick");
  chk_step_one: assert property (s_step |->
    (route.right_level - $past(route.right_level)) == 4'd1 ||
    ($past(route.right_level) - route.right_level) == 4'd1)
    else $error("step size");
  chk_write_resp: assert property (axil_req.awvalid && axil_rsp.awready &&
    axil_req.wvalid && axil_rsp.wready |-> ##2 axil_rsp.bvalid)
    else $error("no bvalid");
  chk_read_resp: assert property (axil_req.arvalid && axil_rsp.arready
    |=> axil_rsp.rvalid) else $error("no rvalid");
  chk_left_rsvd: assert property (axil_rsp.rvalid && ra == 8'h54
    |-> axil_rsp.rdata[2:0] == 3'h0) else $error("reserved bits");
  cover property (axil_rsp.bvalid && axil_req.bready);
  cover property (axil_rsp.rvalid && axil_req.rready);
  cover property (route.right_step_busy ##1 !route.right_step_busy);
endmodule : acr_route_regs_chk
bind acr_route_regs acr_route_regs_chk chk_u (.aclk(aclk),
  .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .fs_tick(fs_tick), .route(route));

// ### test/tb_top.sv
// Self-checking bench for the routing register bank
`timescale 1ns/100ps
module tb_top;
  import acr_pkg::*;
  logic          aclk, aresetn, fs_tick;
  acr_axil_req_t req;
  acr_axil_rsp_t rsp;
  acr_route_t    route;
  int            n_errors, checks_done, seed, i;
  logic [31:0]   d, x;
  logic [1:0]    r;
  logic [3:0]    lv;
  acr_route_regs dut_u (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .fs_tick(fs_tick), .route(route));
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) fs_tick <= ($random(seed) % 4) == 0;
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1;
    w = 1;
    req.awvalid <= 1;
    req.awaddr <= a;
    req.wvalid <= 1;
    req.wdata <= v;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && rsp.awready) req.awvalid <= 0;
      if (w && rsp.wready) req.wvalid <= 0;
      aw = aw && !rsp.awready;
      w = w && !rsp.wready;
    end
    do @(posedge aclk); while (!rsp.bvalid);
    r = rsp.bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    req.arvalid <= 1;
    req.araddr <= a;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 0;
    do @(posedge aclk); while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask : rd
  task automatic wrd(input logic [7:0] a, input logic [31:0] v, e);
    wr(a, v);
    chk("bresp", r, 0);
    rd(a);
    chk("rresp", r, 0);
    chk("rdata", d, e);
  endtask : wrd
  task automatic step(input logic [7:0] v, input logic [3:0] t);
    int n;
    wrd(8'h58, {24'h0, v}, {24'h0, v});
    chk("busy", route.right_step_busy, 1);
    n = 0;
    while (route.right_step_busy === 1'b1 && n < 500) begin
      @(posedge aclk);
      n++;
    end
    chk("level", route.right_level, t);
    chk("connect", route.right_connect, 1);
  endtask : step
  initial begin
    seed = 58979;
    n_errors = 0;
    checks_done = 0;
    aresetn = 0;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1;
    req.rready = 1;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(8'h54);
    chk("left rst", d, 32'h0000_0078);
    rd(8'h58);
    chk("right rst", d, 32'h0000_0078);
    chk("lconn rst", route.left_connect, 0);
    for (i = 0; i < 10; i++) begin
      lv = (i == 9) ? 4'hF : i[3:0];
      x = $random(seed);
      wrd(8'h54, {x[31:8], x[7], lv, 3'h0}, {24'h0, x[7], lv, 3'h0});
      chk("left lvl", route.left_level, lv);
      chk("left conn", route.left_connect, lv != 4'hF);
      chk("left diff", route.left_diff, x[7]);
    end
    for (i = 0; i < 4; i++) begin
      x = $random(seed);
      wrd(8'h58, {x[31:8], x[7], 4'hF, x[2], i[1:0]},
          {24'h0, x[7], 4'hF, x[2], i[1:0]});
      chk("power", route.right_power, x[2]);
      chk("right diff", route.right_diff, x[7]);
    end
    // Left mix now disconnected, so mode bits may differ
    wrd(8'h58, 32'h0000_0006, 32'h0000_0006);
    repeat (3) @(posedge aclk);
    chk("jump", route.right_level, 0);
    step(8'h44, 4'h8);
    step(8'h25, 4'h4);
    wr(8'h00, 32'h0000_00FF);
    chk("unmapped wr", r, 2);
    rd(8'h00);
    chk("unmapped rd", r, 2);
    chk("unmapped data", d, 0);
    report_and_stop;
  end
  initial begin
    repeat (10000) @(posedge aclk);
    n_errors++;
    report_and_stop;
  end
endmodule : tb_top
